// >>> bench/ascl_flash_model.sv
// Behavioural serial flash that answers the loader's read request.
// Assumes a 32 bit header (command, address) before data, MSB first.
`timescale 1ns/1ps
module ascl_flash_model (
   // Link pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   // Header as seen by the flash
   output logic [31:0] hdr
);
   // ------------------------------------------------------------
   // Storage pattern and counters
   // ------------------------------------------------------------
   function automatic logic [7:0] pat(input logic [23:0] a);
      return a[7:0] * 8'h1d ^ 8'h5a;
   endfunction : pat
   int cnt = 0;
   int li = 0;
   logic [7:0] b;
   initial miso = 1'b0;
   // Header bits taken on rises while selected
   always @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         cnt <= 0;
      end else begin
         if (cnt < 32) hdr <= {hdr[30:0], mosi};
         cnt <= cnt + 1;
      end
   end
   // Data launched on falls; a released line shows the inverted bit
   always @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         li <= 0;
         miso <= ~miso;
      end else if (cnt >= 32) begin
         b = pat(hdr[23:0] + 24'(li / 8));
         miso <= b[7 - li % 8];
         li <= li + 1;
      end
   end
endmodule : ascl_flash_model

// >>> bench/tb_ascl_loader.sv
// Self-checking bench of the configuration loader and its flash.
// Assumes the image is read from flash address zero onwards.
`timescale 1ns/1ps
module tb_ascl_loader;
   import ascl_pkg::*;
   // ------------------------------------------------------------
   // Pins and bookkeeping
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic req_n = 1'b0;
   logic ext_low = 1'b0;
   logic [1:0] sel = 2'h0;
   logic chain_n = 1'b1;
   logic cfg_ready = 1'b0;
   logic stall = 1'b0;
   logic ce_on = 1'b1;
   logic oe_n, st_out, chain_out_n, sclk, cs_n, cmd, miso, done;
   logic prev_sclk = 1'b1;
   logic prev_cmd = 1'b0;
   logic [31:0] hdr;
   ascl_byte_type strm;
   wire logic st_line;
   int err_total = 0;
   int tests_run = 0;
   int seed = 93;
   int nbytes = 0;
   int half_min = 1000;
   int run_len = 0;
   always #5 clk = ~clk;
   // Open-drain status line with its pull-up
   assign st_line = (oe_n === 1'b0 || ext_low) ? 1'b0 : 1'b1;
   ascl_loader dut (.clk(clk), .reset(reset), .ce(ce_on),
      .config_request_n(req_n), .cfg_state_line_n_in(st_line),
      .cfg_state_line_n_out(st_out), .cfg_state_line_n_oe_n(oe_n),
      .scheme_select(sel), .chain_enable_in_n(chain_n),
      .chain_enable_out_n(chain_out_n), .serial_cfg_clock(sclk),
      .flash_select_out_n(cs_n), .serial_cmd_out(cmd),
      .serial_data_in(miso), .cfg_stream(strm), .cfg_ready(cfg_ready),
      .cfg_done(done));
   ascl_flash_model flash (.sclk(sclk), .cs_n(cs_n), .mosi(cmd),
      .miso(miso), .hdr(hdr));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] exp_byte(input int k);
      return 8'(k) * 8'h1d ^ 8'h5a;
   endfunction : exp_byte
   // Half period rounded up so the link never beats the setting
   function automatic int exp_half(input logic fast);
      int f;
      f = fast ? 40 : 20;
      return (1000 + 2 * f * 10 - 1) / (2 * f * 10);
   endfunction : exp_half
   task automatic chk(input bit ok, input string m);
      tests_run++;
      if (!ok) begin
         err_total++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask : cycles
   task automatic summarize;
      $display("errors %0d checks %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   // Consumer: random stalls, or a long one to fill the FIFO
   always @(posedge clk) begin
      cfg_ready <= stall ? 1'b0 : (($random(seed) & 32'h3) != 0);
   end
   // Monitor on the settled half of the clock
   always @(negedge clk) begin
      if (cs_n === 1'b0 && sclk !== prev_sclk) begin
         if (run_len < half_min) half_min = run_len;
         run_len = 1;
      end else begin
         run_len = run_len + 1;
      end
      if (cs_n === 1'b0 && cmd !== prev_cmd && !(prev_sclk && !sclk))
         chk(0, "command bit moved off a clock fall");
      if (strm.valid === 1'b1 && cfg_ready === 1'b1 && ce_on === 1'b1) begin
         chk(strm.data === exp_byte(nbytes), "byte mismatch");
         nbytes = nbytes + 1;
      end
      prev_sclk = sclk;
      prev_cmd = cmd;
   end
   // One load; optionally cut short by pulling the status line low
   task automatic run_load(input logic fast, input bit hold, input bit cut);
      int k;
      int c;
      @(posedge clk);
      req_n <= 1'b0;
      // Master strap kept off the passive value 01 that chained slaves use
      sel <= {fast, fast & 1'($random(seed))};
      cycles(10);
      chk(cs_n === 1'b1 && sclk === 1'b1, "link active in reset");
      chk(oe_n === 1'b0, "status not held low");
      // Bytes left over from a cut load are checked in the old count
      while (strm.valid === 1'b1) @(posedge clk);
      nbytes = 0;
      half_min = 1000;
      stall <= hold;
      req_n <= 1'b1;
      cycles(30);
      chk(oe_n === 1'b1 && cs_n === 1'b0,
         "no configuration mode");
      if (hold) begin
         cycles(1500);
         c = flash.cnt;
         cycles(100);
         chk(flash.cnt == c && nbytes == 0, "link ran while full");
         stall <= 1'b0;
      end
      if (cut) begin
         cycles(2000);
         // Clock enable low must freeze link and stream mid-image
         ce_on <= 1'b0;
         cycles(1);
         c = flash.cnt;
         k = nbytes;
         cycles(50);
         chk(flash.cnt == c && nbytes == k && cs_n === 1'b0,
            "clock enable did not freeze");
         ce_on <= 1'b1;
         ext_low <= 1'b1;
         for (k = 0; k < 6 && cs_n !== 1'b1; k++) @(posedge clk);
         chk(cs_n === 1'b1 && sclk === 1'b1, "no abort");
         // Request falls with the status release, so no restart glitch
         req_n <= 1'b0;
         ext_low <= 1'b0;
         return;
      end
      for (k = 0; k < 40000 && done !== 1'b1; k++) @(posedge clk);
      chk(done === 1'b1, "load timed out");
      cycles(100);
      chk(nbytes == 256, "byte count");
      chk(hdr === 32'h03000000, "read header");
      chk(half_min == exp_half(fast), "serial clock rate");
      chk(cs_n === 1'b1 && chain_out_n === 1'b0,
         "end state");
   endtask : run_load
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      cycles(6);
      reset <= 1'b0;
      req_n <= 1'b1;
      cycles(10);
      chk(oe_n === 1'b0, "status released before power-on end");
      cycles(90);
      chk(cs_n === 1'b1, "started with chain disabled");
      // Request drops with chain enable so no one-cycle start slips in
      chain_n <= 1'b0;
      req_n <= 1'b0;
      run_load(1'b0, 1'b1, 1'b0);
      run_load(1'b0, 1'b0, 1'b1);
      run_load(1'b1, 1'b0, 1'b0);
      summarize();
   end
   initial begin
      #900000;
      err_total++;
      summarize();
   end
endmodule : tb_ascl_loader

// >>> logic/ascl_defines.svh
// Constants of the active serial configuration loader.
// Assumes a 100 MHz system clock; included by the package and the loader.
`ifndef ASCL_DEFINES_SVH
`define ASCL_DEFINES_SVH

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define ASCL_CLK_PERIOD_NS 10
`define ASCL_OSC_SLOW_MHZ 20
`define ASCL_OSC_FAST_MHZ 40
// Half period in clk cycles; rounded up so the link never beats the rate
`define ASCL_HALF_CYC(f) \
   ((1000 + 2*(f)*`ASCL_CLK_PERIOD_NS - 1) / \
    (2*(f)*`ASCL_CLK_PERIOD_NS))
`define ASCL_HALF_W 2
`define ASCL_POR_NS 200
`define ASCL_POR_CYC \
   ((`ASCL_POR_NS + `ASCL_CLK_PERIOD_NS - 1) / `ASCL_CLK_PERIOD_NS)
`define ASCL_POR_W 5

// ------------------------------------------------------------------
// Widths, fields and flash transfer
// ------------------------------------------------------------------
`define ASCL_SEL_W 2
`define ASCL_SEL_FAST_BIT 1
`define ASCL_DATA_W 8
`define ASCL_FIFO_DEPTH 8
`define ASCL_READ_CMD 8'h03
`define ASCL_START_ADDR 24'h000000
`define ASCL_HDR_W 32
`define ASCL_HDR_BITS 6'h20
`define ASCL_BYTE_BITS 6'h08
`define ASCL_CNT_W 6
`define ASCL_IMAGE_BYTES 16'h0100
`define ASCL_IMG_W 16

`endif

// >>> logic/ascl_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
// Assumes one clock, asynchronous active-high reset and a clock enable.
`timescale 1ns/1ps
module ascl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input logic clk,
   input logic reset,
   input logic ce,
   // Filling side
   input logic in_valid,
   output logic in_ready,
   input logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   import ascl_pkg::*;

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } ascl_fifo_state_type;

   ascl_fifo_state_type q;
   ascl_fifo_state_type d;
   logic push;
   logic pop;
   logic [DEPTH-1:0] we;

   // ---------------------------------------------------------------
   // Handshakes
   // ---------------------------------------------------------------
   assign in_ready = (q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (q.cnt != '0);
   assign out_data = q.mem[q.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Per-entry write strobes
   for (genvar i = 0; i < DEPTH; i++) begin : g_we
      assign we[i] = push && (q.wp == AW'(i));
   end

   // Next state; pointers wrap since depth is a power of two
   always_comb begin
      d = q;
      for (int i = 0; i < DEPTH; i++) begin
         if (we[i]) begin
            d.mem[i] = in_data;
         end
      end
      if (push) begin
         d.wp = q.wp + 1'b1;
      end
      if (pop) begin
         d.rp = q.rp + 1'b1;
      end
      if (push && !pop) begin
         d.cnt = q.cnt + 1'b1;
      end else if (pop && !push) begin
         d.cnt = q.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   a_fifo_no_overrun: assert property (@(posedge clk) disable iff (reset)
      (q.cnt == (AW+1)'(DEPTH)) |-> !in_ready)
      else $error("fifo accepts data while full");

endmodule : ascl_fifo

// >>> logic/ascl_loader.sv
// Active serial configuration loader: masters a serial flash at power-up
// and streams the image to the core through a small FIFO.
// Assumes a 100 MHz clk; all pins except cfg_ready come from outside.
//
// Function
// - Stay in reset while config request or status line reads low.
// - Make serial clock internally at a 20 or 40 MHz scheme setting; here about 16.7 or 25 MHz.
// - Launch control outputs and capture flash data on falling edges.
// - Drive flash select low while configuring.
// - Shift read command and address out serially on the command pin.
// - Chain-enable input held low; all devices load the same data.
// - Unused chain-enable output may float or act as user I/O.
`timescale 1ns/1ps
`include "ascl_defines.svh"

module ascl_loader (
   // Clock, reset and enable
   input logic clk,
   input logic reset,
   input logic ce,
   // Configuration control pins
   input logic config_request_n,
   input logic cfg_state_line_n_in,
   output logic cfg_state_line_n_out,
   output logic cfg_state_line_n_oe_n,
   input logic [`ASCL_SEL_W-1:0] scheme_select,
   input logic chain_enable_in_n,
   output logic chain_enable_out_n,
   // Serial flash link
   output logic serial_cfg_clock,
   output logic flash_select_out_n,
   output logic serial_cmd_out,
   input logic serial_data_in,
   // Image stream towards the core
   output ascl_pkg::ascl_byte_type cfg_stream,
   input logic cfg_ready,
   output logic cfg_done
);
   import ascl_pkg::*;

   // ---------------------------------------------------------------
   // Reset image of the state
   // ---------------------------------------------------------------
   localparam ascl_reg_type Q_RST = '{
      state: st_reset,
      por_cnt: `ASCL_POR_W'(`ASCL_POR_CYC),
      sclk: 1'b1,
      cs_n: 1'b1,
      default: '0
   };
   localparam logic [`ASCL_HALF_W-1:0] HALF_SLOW =
      `ASCL_HALF_W'(`ASCL_HALF_CYC(`ASCL_OSC_SLOW_MHZ));
   localparam logic [`ASCL_HALF_W-1:0] HALF_FAST =
      `ASCL_HALF_W'(`ASCL_HALF_CYC(`ASCL_OSC_FAST_MHZ));

   ascl_reg_type q;
   ascl_reg_type d;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [`ASCL_DATA_W-1:0] fifo_out_data;

   // ---------------------------------------------------------------
   // Image FIFO; its fullness stalls the serial clock
   // ---------------------------------------------------------------
   ascl_fifo #(
      .WIDTH(`ASCL_DATA_W),
      .DEPTH(`ASCL_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .in_valid(q.pend),
      .in_ready(fifo_in_ready),
      .in_data(q.rx),
      .out_valid(fifo_out_valid),
      .out_ready(cfg_ready),
      .out_data(fifo_out_data)
   );

   // ---------------------------------------------------------------
   // Pin outputs
   // ---------------------------------------------------------------
   // Open drain: only ever pulls low, during power-on or a request
   assign cfg_state_line_n_out = 1'b0;
   assign cfg_state_line_n_oe_n = !((q.por_cnt != '0) || !q.cr_s2);
   assign serial_cfg_clock = q.sclk;
   assign flash_select_out_n = q.cs_n;
   assign serial_cmd_out = q.cmd;
   // Low once loaded; free for user I/O if nothing follows
   assign chain_enable_out_n = !q.done;
   assign cfg_done = q.done;
   assign cfg_stream.valid = fifo_out_valid;
   assign cfg_stream.data = fifo_out_data;

   // ---------------------------------------------------------------
   // Sequencer and serial engine
   // ---------------------------------------------------------------
   // One half-period counter drives both edges; falling edge launches
   // command bits and captures data, so the flash sees settled bits on
   // its rising edge and we read what it launched one fall earlier.
   always_comb begin
      logic stall;
      stall = 1'b0;
      d = q;
      // Two-flop synchronisers for every pin input
      d.cr_s1 = config_request_n;
      d.cr_s2 = q.cr_s1;
      d.st_s1 = cfg_state_line_n_in;
      d.st_s2 = q.st_s1;
      d.ce_s1 = chain_enable_in_n;
      d.ce_s2 = q.ce_s1;
      d.dq_s1 = serial_data_in;
      d.dq_s2 = q.dq_s1;
      d.ms_s1 = scheme_select;
      d.ms_s2 = q.ms_s1;
      if (q.por_cnt != '0) begin
         d.por_cnt = q.por_cnt - 1'b1;
      end
      if (!q.cr_s2 || !q.st_s2) begin
         // Held in reset stage, flash idle and deselected
         d.state = st_reset;
         d.sclk = 1'b1;
         d.cs_n = 1'b1;
         d.cmd = 1'b0;
         d.pend = 1'b0;
         d.done = 1'b0;
      end else begin
         case (q.state)
            st_reset: begin
               // Status line high: configuration mode starts here
               if (!q.ce_s2) begin
                  d.state = st_send;
                  d.cs_n = 1'b0;
                  d.fast = q.ms_s2[`ASCL_SEL_FAST_BIT];
                  d.half = q.ms_s2[`ASCL_SEL_FAST_BIT] ? HALF_FAST
                                                       : HALF_SLOW;
                  d.tx = {`ASCL_READ_CMD, `ASCL_START_ADDR};
                  d.bit_cnt = `ASCL_HDR_BITS;
                  d.byte_cnt = `ASCL_IMAGE_BYTES;
               end
            end
            st_send, st_read: begin
               if (q.pend && fifo_in_ready) begin
                  d.pend = 1'b0;
               end
               // Back-pressure: hold the link until the byte is taken
               stall = (q.pend && !fifo_in_ready) || (q.byte_cnt == '0);
               if (q.state == st_read && q.byte_cnt == '0 && !q.pend) begin
                  d.state = st_done;
                  d.cs_n = 1'b1;
                  d.sclk = 1'b1;
                  d.done = 1'b1;
               end else if (!stall) begin
                  if (q.half != `ASCL_HALF_W'(1)) begin
                     d.half = q.half - 1'b1;
                  end else begin
                     d.half = q.fast ? HALF_FAST : HALF_SLOW;
                     d.sclk = !q.sclk;
                     if (q.sclk) begin
                        // Falling edge
                        if (q.state == st_send) begin
                           d.cmd = q.tx[`ASCL_HDR_W-1];
                           d.tx = {q.tx[`ASCL_HDR_W-2:0], 1'b0};
                        end else if (q.first) begin
                           // Flash only launches its first bit now
                           d.first = 1'b0;
                        end else begin
                           d.rx = {q.rx[`ASCL_DATA_W-2:0], q.dq_s2};
                           d.bit_cnt = q.bit_cnt - 1'b1;
                           if (q.bit_cnt == `ASCL_CNT_W'(1)) begin
                              d.pend = 1'b1;
                              d.bit_cnt = `ASCL_BYTE_BITS;
                              d.byte_cnt = q.byte_cnt - 1'b1;
                           end
                        end
                     end else if (q.state == st_send) begin
                        // Rising edge: flash has taken one header bit
                        d.bit_cnt = q.bit_cnt - 1'b1;
                        if (q.bit_cnt == `ASCL_CNT_W'(1)) begin
                           d.state = st_read;
                           d.first = 1'b1;
                           d.bit_cnt = `ASCL_BYTE_BITS;
                        end
                     end
                  end
               end
            end
            default: begin
               // Loaded: stay until a new request
               d.cs_n = 1'b1;
            end
         endcase
      end
   end

   // State register; clock enable freezes everything
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= Q_RST;
      end else if (ce) begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_reset_stage_hold: assert property (
      @(posedge clk) disable iff (reset)
      (ce && (!q.cr_s2 || !q.st_s2)) |=> (q.state == st_reset && q.cs_n))
      else $error("reset stage left while request or status low");

   a_status_release: assert property (
      @(posedge clk) disable iff (reset)
      (q.por_cnt == '0 && q.cr_s2) |-> cfg_state_line_n_oe_n)
      else $error("status line still pulled low after power-on");

   a_clock_half_min: assert property (
      @(posedge clk) disable iff (reset)
      (ce && q.state == st_send && $changed(q.sclk)) |=> $stable(q.sclk))
      else $error("serial clock half period shorter than two cycles");

   a_cmd_on_fall: assert property (
      @(posedge clk) disable iff (reset)
      (q.state == st_send && $past(q.state) == st_send && $changed(q.cmd))
      |-> $fell(q.sclk))
      else $error("command bit changed away from a falling edge");

   a_data_on_fall: assert property (
      @(posedge clk) disable iff (reset)
      ($past(q.state) == st_read && q.state == st_read && $changed(q.rx))
      |-> $fell(q.sclk))
      else $error("data captured away from a falling edge");

   a_select_active: assert property (
      @(posedge clk) disable iff (reset)
      (q.state == st_send || q.state == st_read) |-> !flash_select_out_n)
      else $error("flash not selected during configuration");

   a_cmd_msb_first: assert property (
      @(posedge clk) disable iff (reset)
      (q.state == st_send && $fell(q.sclk) &&
       $past(q.bit_cnt) == `ASCL_HDR_BITS) |-> (q.cmd == `ASCL_READ_CMD >> 7))
      else $error("first command bit is not the read command msb");

   a_chain_gate: assert property (
      @(posedge clk) disable iff (reset)
      (ce && q.state == st_reset && q.ce_s2) |=> q.state == st_reset)
      else $error("configuration started with chain enable high");

   a_done_release: assert property (
      @(posedge clk) disable iff (reset)
      (q.state == st_done) |-> (!chain_enable_out_n && flash_select_out_n
                                && serial_cfg_clock))
      else $error("done state with link busy or chain output high");

   a_idle_in_reset: assert property (
      @(posedge clk) disable iff (reset)
      (q.state == st_reset) |-> (flash_select_out_n && serial_cfg_clock))
      else $error("flash link active in reset stage");

   // Entry, clock rate, counter bounds, back-pressure, idle and done states of the engine
   a_enter_config: assert property (
      @(posedge clk) disable iff (reset)
      (ce && q.state == st_reset && q.cr_s2 && q.st_s2 && !q.ce_s2)
      |=> (q.state == st_send && !q.cs_n))
      else $error("configuration mode not entered with all pins ready");

   a_clock_toggle: assert property (
      @(posedge clk) disable iff (reset)
      (ce && q.cr_s2 && q.st_s2 && q.state == st_send &&
       q.half == `ASCL_HALF_W'(1)) |=> $changed(q.sclk))
      else $error("serial clock missed its toggle in the header phase");

   a_half_range: assert property (
      @(posedge clk) disable iff (reset)
      (q.state == st_send || q.state == st_read)
      |-> (q.half != '0 && q.half <= HALF_SLOW))
      else $error("half period count out of range");

   a_fast_half: assert property (
      @(posedge clk) disable iff (reset)
      ((q.state == st_send || q.state == st_read) && q.fast)
      |-> (q.half <= HALF_FAST))
      else $error("fast setting runs a slow half period");

   a_header_count: assert property (
      @(posedge clk) disable iff (reset)
      (q.state == st_send)
      |-> (q.bit_cnt != '0 && q.bit_cnt <= `ASCL_HDR_BITS))
      else $error("header bit count out of range");

   a_byte_count: assert property (
      @(posedge clk) disable iff (reset)
      (q.state == st_read)
      |-> (q.bit_cnt != '0 && q.bit_cnt <= `ASCL_BYTE_BITS))
      else $error("data bit count out of range");

   a_stall_hold: assert property (
      @(posedge clk) disable iff (reset)
      (ce && q.cr_s2 && q.st_s2 && q.state == st_read && q.pend &&
       !fifo_in_ready) |=> $stable(q.sclk))
      else $error("serial clock moved while the FIFO was full");

   a_cmd_reset_low: assert property (
      @(posedge clk) disable iff (reset)
      (q.state == st_reset) |-> !serial_cmd_out)
      else $error("command pin not idle in reset stage");

   a_done_stable: assert property (
      @(posedge clk) disable iff (reset)
      (ce && q.cr_s2 && q.st_s2 && q.state == st_done)
      |=> (q.state == st_done && !chain_enable_out_n))
      else $error("done state left without a new request");

   a_abort_idle: assert property (
      @(posedge clk) disable iff (reset)
      (ce && !q.st_s2)
      |=> (flash_select_out_n && serial_cfg_clock && !q.done))
      else $error("status low did not idle the flash link");

endmodule : ascl_loader

// >>> logic/ascl_pkg.sv
// Types shared by the configuration loader and its data FIFO.
// Assumes ascl_defines.svh is on the include path.
package ascl_pkg;
`include "ascl_defines.svh"

   // ---------------------------------------------------------------
   // Sequencer states, Gray coded along reset, send, read, done
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      st_reset = 2'h0,
      st_send = 2'h1,
      st_read = 2'h3,
      st_done = 2'h2
   } ascl_state_type;

   // Configuration byte stream towards the core
   typedef struct packed {
      logic valid;
      logic [`ASCL_DATA_W-1:0] data;
   } ascl_byte_type;

   // Whole state of the loader
   typedef struct packed {
      logic cr_s1;
      logic cr_s2;
      logic st_s1;
      logic st_s2;
      logic ce_s1;
      logic ce_s2;
      logic dq_s1;
      logic dq_s2;
      logic [`ASCL_SEL_W-1:0] ms_s1;
      logic [`ASCL_SEL_W-1:0] ms_s2;
      ascl_state_type state;
      logic [`ASCL_POR_W-1:0] por_cnt;
      logic [`ASCL_HALF_W-1:0] half;
      logic fast;
      logic sclk;
      logic cs_n;
      logic cmd;
      logic [`ASCL_HDR_W-1:0] tx;
      logic [`ASCL_CNT_W-1:0] bit_cnt;
      logic first;
      logic [`ASCL_DATA_W-1:0] rx;
      logic pend;
      logic [`ASCL_IMG_W-1:0] byte_cnt;
      logic done;
   } ascl_reg_type;

endpackage : ascl_pkg
